// ### core/sarc_readout.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_readout #(
  parameter int BUF_DEPTH = sarc_pkg::BUF_DEPTH
) (
  input wire logic clk,                   // system clock, 50 MHz
  input wire logic rst_n,                 // async reset, active low
  input wire logic ce,                    // clock enable, freezes clk-domain state
  input wire logic chip_select_n,         // select pin, active low
  input wire logic serial_shift_clock,    // shift clock pin from host
  input wire logic [7:0] analog_level,    // digitised stand-in for the analog input
  input wire logic sample_host_mode,      // 1: hold taken at access start
  output logic serial_result_out,         // serial data out
  output logic serial_result_oe_n,        // 0 while driving, 1 released
  output logic conv_busy                  // conversion in progress or storing
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic [7:0] level_meta_ff;
  logic [7:0] level_sync_ff;
  logic mode_meta_ff;
  logic mode_sync_ff;
  logic link_clr;
  logic [3:0] edge_cnt_ff;
  logic [3:0] edge_gray_ff;
  logic [3:0] nxt_edge_cnt;
  logic [3:0] gray_meta_ff;
  logic [3:0] gray_sync_ff;
  logic [3:0] edges_link;
  logic [3:0] edges_done_ff;
  logic [3:0] div_ff;
  logic int_rise;
  logic int_fall;
  sarc_pkg::sarc_access_t ac_state_ff;
  logic [1:0] rises_ff;
  logic [7:0] shift_ff;
  logic dout_ff;
  logic oe_n_ff;
  logic access_load;
  logic edge_pending;
  logic conv_start;
  sarc_pkg::sarc_conv_t cv_state_ff;
  logic [5:0] period_ff;
  logic [1:0] step_ff;
  logic [2:0] bit_ff;
  logic [7:0] held_ff;
  logic [7:0] approx_ff;
  logic [7:0] trial;
  logic [9:0] guard_ff;
  logic guard_hit;
  logic timed_out_ff;
  logic busy_ff;
  sarc_pkg::sarc_word_t store_word;
  sarc_pkg::sarc_word_t head_word;
  logic [sarc_pkg::WORD_W-1:0] head_bits;
  logic buf_in_ready;
  logic buf_out_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any clk-domain logic looks at a pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      mode_meta_ff <= 1'b0;
      mode_sync_ff <= 1'b0;
    end else if (ce) begin
      cs_meta_ff <= chip_select_n;
      cs_sync_ff <= cs_meta_ff;
      mode_meta_ff <= sample_host_mode;
      mode_sync_ff <= mode_meta_ff;
    end
  end

  // analog level is quasi-static; bitwise sync is enough at the hold point
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_meta_ff <= sarc_pkg::CODE_RST;
      level_sync_ff <= sarc_pkg::CODE_RST;
    end else if (ce) begin
      level_meta_ff <= analog_level;
      level_sync_ff <= level_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link domain: count shift-clock trailing edges of one access
  // the shift clock may stop between accesses, so the count is cleared by
  // select going high rather than by any edge of the shift clock
  assign link_clr = chip_select_n | ~rst_n;

  // saturate at eight; surplus pulses of an access are ignored
  assign nxt_edge_cnt = (edge_cnt_ff == sarc_pkg::EDGES_PER_ACCESS) ?
                        edge_cnt_ff : edge_cnt_ff + 4'h1;

  // count and its gray copy, only the gray copy crosses
  always_ff @(negedge serial_shift_clock or posedge link_clr) begin
    if (link_clr) begin
      edge_cnt_ff <= sarc_pkg::CNT_RST;
      edge_gray_ff <= sarc_pkg::CNT_RST;
    end else begin
      edge_cnt_ff <= nxt_edge_cnt;                // see (R7)
      edge_gray_ff <= nxt_edge_cnt ^ (nxt_edge_cnt >> 1);
    end
  end

  // gray count into the system clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gray_meta_ff <= sarc_pkg::CNT_RST;
      gray_sync_ff <= sarc_pkg::CNT_RST;
    end else if (ce) begin
      gray_meta_ff <= edge_gray_ff;
      gray_sync_ff <= gray_meta_ff;
    end
  end

  assign edges_link = {gray_sync_ff[3], ^gray_sync_ff[3:2], ^gray_sync_ff[3:1], ^gray_sync_ff[3:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // internal system clock, derived from clk by a divider
  // it free-runs regardless of the shift clock, which keeps conversion
  // timing independent of how the host paces its accesses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= sarc_pkg::CNT_RST;
    end else if (ce) begin
      div_ff <= (div_ff == sarc_pkg::DIV_LAST) ? sarc_pkg::CNT_RST : div_ff + 4'h1; // see (R9)
    end
  end

  assign int_rise = (div_ff == sarc_pkg::DIV_LAST);                    // see (R10)
  assign int_fall = (div_ff == sarc_pkg::DIV_FALL);

  ////////////////////////////////////////////////////////////////////////////////
  // access control
  // the word is loaded once select has settled; one edge is handled per cycle,
  // so edges that came early during the settle time are caught up after it
  assign access_load = (ac_state_ff == sarc_pkg::AC_SETTLE) && (rises_ff == sarc_pkg::SETTLE_RISES)
                       && int_fall && !cs_sync_ff;
  assign edge_pending = (ac_state_ff == sarc_pkg::AC_SHIFT) && !cs_sync_ff
                        && (edges_done_ff != edges_link);
  assign conv_start = edge_pending
                      && (edges_done_ff + 4'h1 == sarc_pkg::EDGES_PER_ACCESS); // see (R2)

  // access state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_state_ff <= sarc_pkg::AC_IDLE;
      rises_ff <= 2'h0;
    end else if (ce) begin
      unique case (ac_state_ff)
        sarc_pkg::AC_IDLE: begin
          rises_ff <= 2'h0;
          if (!cs_sync_ff) begin
            ac_state_ff <= sarc_pkg::AC_SETTLE;
          end
        end
        sarc_pkg::AC_SETTLE: begin
          // noise filter: two internal rises, then one internal fall
          if (cs_sync_ff) begin
            ac_state_ff <= sarc_pkg::AC_IDLE;
          end else if (access_load) begin
            ac_state_ff <= sarc_pkg::AC_SHIFT;             // see (R16)
          end else if (int_rise && rises_ff != sarc_pkg::SETTLE_RISES) begin
            rises_ff <= rises_ff + 2'h1;                  // see (R16)
          end
        end
        sarc_pkg::AC_SHIFT: begin
          if (cs_sync_ff) begin
            ac_state_ff <= sarc_pkg::AC_IDLE;
          end
        end
        default: begin
          ac_state_ff <= sarc_pkg::AC_IDLE;
        end
      endcase
    end
  end

  // edges already acted upon in this access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_done_ff <= sarc_pkg::CNT_RST;
    end else if (ce) begin
      if (ac_state_ff != sarc_pkg::AC_SHIFT) begin
        edges_done_ff <= sarc_pkg::CNT_RST;
      end else if (edge_pending) begin
        edges_done_ff <= edges_done_ff + 4'h1;
      end
    end
  end

  // result shifter and the serial output flop
  // with the buffer empty the last word is sent again rather than junk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= sarc_pkg::CODE_RST;
      dout_ff <= 1'b0;
    end else if (ce) begin
      if (access_load) begin
        if (buf_out_valid) begin
          shift_ff <= head_word.code;                         // see (R5)
          dout_ff <= head_word.code[sarc_pkg::MSB_IDX];       // see (R3)
        end else begin
          dout_ff <= shift_ff[sarc_pkg::MSB_IDX];             // see (R3)
        end
      end else if (edge_pending) begin
        shift_ff <= {shift_ff[6:0], shift_ff[7]};             // eighth turn restores the word
        if (!conv_start) begin
          dout_ff <= shift_ff[6];                             // see (R4)
        end
      end
    end
  end

  // three-state control, released whenever not selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_ff <= 1'b1;
    end else if (ce) begin
      if (cs_sync_ff || ac_state_ff == sarc_pkg::AC_IDLE) begin
        oe_n_ff <= 1'b1;                                      // see (R6)
      end else if (access_load) begin
        oe_n_ff <= 1'b0;                                      // see (R6)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion
  assign trial = approx_ff | (8'h01 << bit_ff);
  assign guard_hit = (guard_ff == sarc_pkg::CONV_MAX_LAST);

  // conversion state machine, paced by the internal clock only
  // a start while a conversion or store is still pending is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cv_state_ff <= sarc_pkg::CV_IDLE;
      period_ff <= 6'h00;
      step_ff <= 2'h0;
      bit_ff <= sarc_pkg::MSB_IDX;
      approx_ff <= sarc_pkg::CODE_RST;
    end else if (ce) begin
      unique case (cv_state_ff)
        sarc_pkg::CV_IDLE: begin
          if (conv_start) begin
            cv_state_ff <= sarc_pkg::CV_SAMPLE;               // see (R2)
            period_ff <= 6'h00;
          end
        end
        sarc_pkg::CV_SAMPLE: begin
          if (guard_hit) begin
            cv_state_ff <= sarc_pkg::CV_STORE;
          end else if (int_rise) begin
            period_ff <= period_ff + 6'h01;                   // see (R1)
            if (period_ff == sarc_pkg::SAMPLE_LAST) begin
              cv_state_ff <= sarc_pkg::CV_APPROX;
              step_ff <= 2'h0;
              bit_ff <= sarc_pkg::MSB_IDX;                    // see (R11)
              approx_ff <= sarc_pkg::CODE_RST;
            end
          end
        end
        sarc_pkg::CV_APPROX: begin
          if (guard_hit) begin
            cv_state_ff <= sarc_pkg::CV_STORE;
          end else if (int_rise) begin
            period_ff <= period_ff + 6'h01;
            step_ff <= step_ff + 2'h1;
            if (step_ff == sarc_pkg::BIT_LAST) begin
              // keep the trial bit when the held level reaches it
              if (held_ff >= trial) begin
                approx_ff <= trial;                           // see (R11)
              end
              if (period_ff == sarc_pkg::CONV_LAST) begin
                cv_state_ff <= sarc_pkg::CV_STORE;            // see (R1)
              end else begin
                bit_ff <= bit_ff - 3'h1;                      // see (R11)
              end
            end
          end
        end
        sarc_pkg::CV_STORE: begin
          // stall here while the buffer is full; no result is lost
          if (buf_in_ready) begin
            cv_state_ff <= sarc_pkg::CV_IDLE;                 // see (R13)
          end
        end
      endcase
    end
  end

  // sample and hold: at conversion start, or at access start in host mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= sarc_pkg::CODE_RST;
    end else if (ce) begin
      if (mode_sync_ff && access_load) begin
        held_ff <= level_sync_ff;                             // see (R12)
      end else if (!mode_sync_ff && conv_start && cv_state_ff == sarc_pkg::CV_IDLE) begin
        held_ff <= level_sync_ff;                             // see (R12)
      end
    end
  end

  // time guard: a conversion never outlasts its longest time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_ff <= 10'h000;
      timed_out_ff <= 1'b0;
    end else if (ce) begin
      if (cv_state_ff == sarc_pkg::CV_SAMPLE || cv_state_ff == sarc_pkg::CV_APPROX) begin
        guard_ff <= guard_hit ? guard_ff : guard_ff + 10'h001; // see (R1)
        timed_out_ff <= guard_hit;
      end else if (cv_state_ff == sarc_pkg::CV_IDLE) begin
        guard_ff <= 10'h000;
        timed_out_ff <= 1'b0;
      end
    end
  end

  // busy flag, high from start until the word is stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (cv_state_ff == sarc_pkg::CV_IDLE) begin
        busy_ff <= conv_start;
      end else if (cv_state_ff == sarc_pkg::CV_STORE && buf_in_ready) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // result buffer between converter and readout
  assign store_word.timed_out = timed_out_ff;
  assign store_word.code = approx_ff;
  assign head_word = sarc_pkg::sarc_word_t'(head_bits);

  sarc_buf #(
    .W(sarc_pkg::WORD_W),
    .DEPTH(BUF_DEPTH),
    .AW($clog2(BUF_DEPTH))
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(cv_state_ff == sarc_pkg::CV_STORE),
    .in_ready(buf_in_ready),
    .in_data(store_word),
    .out_valid(buf_out_valid),
    .out_ready(access_load),
    .out_data(head_bits)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign serial_result_out = dout_ff;
  assign serial_result_oe_n = oe_n_ff;
  assign conv_busy = busy_ff;

endmodule
`default_nettype wire

// ### core/sarc_pkg.sv
// Overview of operation
// (R1) a conversion lasts 36 internal clock periods and ends within 17 us
// (R2) the eighth shift-clock trailing edge after select falls starts a conversion
// (R3) the result msb appears on the output once selected, with no shift edge
// (R4) the seven lower bits follow, one per shift-clock falling edge, msb first
// (R5) the next access delivers the result of the conversion started before it
// (R6) the serial output is three-state and released while deselected
// (R7) only select and shift clock control all data transfer
// (R8) host keeps the shift clock at or under 2.048 MHz or 1.1 MHz
// (R9) an internal 4 MHz system clock is made on chip and times conversions
// (R10) conversion runs independently of shift-clock timing
// (R11) an 8-bit successive-approximation search resolves one bit per step, msb first
// (R12) sample and hold runs automatically or under host control
// (R13) access plus conversion sustains 45 500 or 40 000 conversions per second
// (R14) host holds select high at least 17 us during a conversion
// (R15) host holds select low at least 1.4 us before the first shift edge
// (R16) after select falls, wait two internal rises and one fall before acting
// (R17) host gives exactly eight shift pulses and captures each bit before the next
package sarc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // result word
  localparam int CODE_W = 8;
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic [2:0] MSB_IDX = 3'h7;

  typedef struct packed {
    logic timed_out;               // conversion cut short by the time guard
    logic [CODE_W-1:0] code;       // converted value
  } sarc_word_t;

  localparam int WORD_W = $bits(sarc_word_t);
  localparam int BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INT_CLK_MHZ = 4;
  // internal clock divider, rounded down so the clock is never slower than 4 MHz
  localparam int SYS_DIV = 1000 / (INT_CLK_MHZ * CLK_PERIOD_NS);
  localparam logic [3:0] DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] DIV_FALL = 4'(SYS_DIV / 2);

  localparam int CONV_PERIODS = 36;
  // the first internal rise only aligns the count, so 36 whole periods follow it
  localparam logic [5:0] CONV_LAST = 6'(CONV_PERIODS);
  localparam logic [5:0] SAMPLE_LAST = 6'h04;
  localparam logic [1:0] BIT_LAST = 2'h3;

  // longest conversion, rounded down to whole cycles
  localparam int CONV_MAX_US = 17;
  localparam int CONV_MAX_CYC = CONV_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_MAX_LAST = 10'(CONV_MAX_CYC - 1);

  localparam logic [1:0] SETTLE_RISES = 2'h2;
  localparam logic [3:0] EDGES_PER_ACCESS = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [1:0] {
    AC_IDLE   = 2'b00,
    AC_SETTLE = 2'b01,
    AC_SHIFT  = 2'b10
  } sarc_access_t;

  typedef enum logic [1:0] {
    CV_IDLE   = 2'b00,
    CV_SAMPLE = 2'b01,
    CV_APPROX = 2'b10,
    CV_STORE  = 2'b11
  } sarc_conv_t;

endpackage

// ### core/sarc_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_buf #(
  parameter int W = 9,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  input wire logic clk,              // system clock
  input wire logic rst_n,            // async reset, active low
  input wire logic ce,               // clock enable
  input wire logic in_valid,         // word offered
  output logic in_ready,             // room for a word
  input wire logic [W-1:0] in_data,  // word in
  output logic out_valid,            // word held
  input wire logic out_ready,        // drain takes the word
  output logic [W-1:0] out_data      // oldest word
);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // honest flags straight from the fill count
  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/sarc_readout_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_readout_asserts #(
  parameter int BUF_DEPTH = sarc_pkg::BUF_DEPTH
) (
  input wire logic clk,                 // system clock
  input wire logic rst_n,               // reset, active low
  input wire logic ce,                  // clock enable
  input wire logic chip_select_n,       // select
  input wire logic serial_shift_clock,  // shift clock
  input wire logic [7:0] analog_level,  // level in
  input wire logic sample_host_mode,    // hold mode
  input wire logic serial_result_out,   // data out
  input wire logic serial_result_oe_n,  // out enable, low drives
  input wire logic conv_busy            // converting
);
  logic [9:0] busy_cnt_ff;
  logic [3:0] sck_falls_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // busy length, so the lower bound of a conversion can be judged at its end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_ff <= 10'h000;
    end else begin
      busy_cnt_ff <= conv_busy ? busy_cnt_ff + 10'h001 : 10'h000;
    end
  end
  // falls seen since select fell; kept after deselect since a start may lag it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_falls_ff <= 4'h0;
    end else if ($fell(chip_select_n)) begin
      sck_falls_ff <= 4'h0;
    end else if (!chip_select_n && $fell(serial_shift_clock) && sck_falls_ff != 4'hF) begin
      sck_falls_ff <= sck_falls_ff + 4'h1;
    end
  end
  AST_RELEASE_IDLE: assert property (chip_select_n [*5] |-> serial_result_oe_n)
    else $error("output driven while deselected");
  AST_DRIVE_SELECTED: assert property (!serial_result_oe_n |-> !$past(chip_select_n, 4))
    else $error("output driven without select");
  AST_MSB_PRESENT: assert property ($fell(chip_select_n) |-> ##[1:45] (!serial_result_oe_n || chip_select_n))
    else $error("msb not presented after select");
  AST_SETTLE_WAIT: assert property ($fell(chip_select_n) |-> serial_result_oe_n [*8])
    else $error("output driven before settle time");
  AST_CONV_MIN: assert property ($fell(conv_busy) |-> busy_cnt_ff >= 10'h1AF)
    else $error("conversion shorter than 36 internal periods");
  AST_START_EIGHTH: assert property ($rose(conv_busy) |-> sck_falls_ff == 4'h8)
    else $error("conversion started on wrong edge count");
  AST_BIT_ON_FALL: assert property ($changed(serial_result_out) && !serial_result_oe_n
      && $past(!serial_result_oe_n) && !$past(chip_select_n, 4)
      |-> $past(serial_shift_clock, 6) && !$past(serial_shift_clock, 2))
    else $error("data bit moved without a shift fall");
  AST_CONV_MAX: assert property ($rose(conv_busy) |-> ##[1:850] !conv_busy)
    else $error("conversion exceeded 17 us");
endmodule
bind sarc_readout sarc_readout_asserts #(.BUF_DEPTH(BUF_DEPTH)) u_chk (.clk(clk), .rst_n(rst_n),
  .ce(ce), .chip_select_n(chip_select_n), .serial_shift_clock(serial_shift_clock),
  .analog_level(analog_level), .sample_host_mode(sample_host_mode),
  .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
  .conv_busy(conv_busy));
`default_nettype wire

// ### testbench/sarc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sarc_host (
  input wire logic lclk,                // 48 ns link base clock
  input wire logic go,                  // request one access
  input wire logic slow,                // 1: slower variant pacing
  input wire logic data_in,             // resolved data wire
  output var logic chip_select_n,       // select, active low
  output var logic serial_shift_clock,  // shift clock, still between frames
  output var logic [7:0] rx_byte,       // received word
  output var logic done,                // pulse at access end
  output var logic idle                 // ready for a request
);
  int half;
  // select and shift clock alone pace every access
  initial begin
    chip_select_n = 1'b1;
    serial_shift_clock = 1'b0;
    rx_byte = 8'h00;
    done = 1'b0;
    idle = 1'b1;
    forever begin
      @(posedge lclk);
      if (go) begin
        idle = 1'b0;
        half = slow ? 10 : 6;  // 960 or 576 ns period
        chip_select_n = 1'b0;
        repeat (32) @(posedge lclk);  // 1.536 us setup
        for (int i = 0; i < 8; i++) begin  // eight pulses
          serial_shift_clock = 1'b1;
          rx_byte = {rx_byte[6:0], data_in};  // taken before the next fall
          repeat (half) @(posedge lclk);
          serial_shift_clock = 1'b0;
          repeat (half) @(posedge lclk);
        end
        chip_select_n = 1'b1;
        done = 1'b1;
        @(posedge lclk);
        done = 1'b0;
        repeat (360) @(posedge lclk);  // 17.28 us high
        idle = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module testbench;
  logic clk, rst_n, ce, sample_host_mode, lclk, go, slow;
  logic [7:0] analog_level, prev_code, exp_b, rx_byte;
  logic serial_result_out, serial_result_oe_n, conv_busy;
  logic chip_select_n, serial_shift_clock, done, idle;
  wire data_wire;
  int bad_count, comparisons, cycles, seed, k;
  logic [7:0] exp_q[$];
  // a released wire shows the inverse, so a bit taken while undriven reads wrong
  assign data_wire = serial_result_oe_n ? ~serial_result_out : serial_result_out;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // link base clock, phase unrelated to clk
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  sarc_readout #(.BUF_DEPTH(2)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .chip_select_n(chip_select_n), .serial_shift_clock(serial_shift_clock),
    .analog_level(analog_level), .sample_host_mode(sample_host_mode),
    .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
    .conv_busy(conv_busy));
  sarc_host host (.lclk(lclk), .go(go), .slow(slow), .data_in(data_wire),
    .chip_select_n(chip_select_n), .serial_shift_clock(serial_shift_clock),
    .rx_byte(rx_byte), .done(done), .idle(idle));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (exp_q.size() != 0) bad_count++;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, nearly three times the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end
  // each finished access is judged against the oldest note
  always @(posedge done) begin
    exp_b = exp_q.pop_front();
    `CHK(rx_byte, exp_b)
    `CHK(conv_busy, 1'b1)
  end
  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    prev_code = sarc_pkg::CODE_RST;
    `CHK(serial_result_oe_n, 1'b1)
    `CHK(conv_busy, 1'b0)
  endtask
  // level is held until the next access, so either hold mode sees it
  task automatic access(input logic slow_i, input logic mode_i);
    logic [7:0] lvl;
    lvl = 8'($random(seed));
    @(negedge clk);
    slow = slow_i;
    sample_host_mode = mode_i;
    analog_level = lvl;
    exp_q.push_back(prev_code);
    prev_code = lvl;
    go = 1'b1;
    k = 0;
    while (idle && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) bad_count++;
    go = 1'b0;
    k = 0;
    while (!idle && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k == 2000) bad_count++;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sample_host_mode = 1'b0;
    analog_level = 8'h00;
    go = 1'b0;
    slow = 1'b0;
    seed = 11;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    prev_code = sarc_pkg::CODE_RST;
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 4; i++) access(1'b0, 1'b0);
    $display("test fast host done");
    for (int i = 0; i < 3; i++) access(1'b1, 1'b1);
    $display("test slow host done");
    ce = 1'b0;
    repeat (40) @(negedge clk);
    ce = 1'b1;
    access(1'b0, 1'b1);
    access(1'b0, 1'b0);
    $display("test clock enable done");
    access(1'b0, 1'b0);
    do_reset();
    access(1'b0, 1'b0);
    access(1'b1, 1'b0);
    $display("test second reset done");
    repeat (10) @(negedge clk);
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
